// ==== design/eeprom_aux_pkg.sv ====
// shared constants, types and states of the auxiliary-space read block
`default_nettype none
package eeprom_aux_pkg;

	// ****************************************************************
	// select code and address decode
	// ****************************************************************
	localparam logic [3:0] ARRAY_TYPE  = 4'ha; // device type of main array
	localparam logic [3:0] AUX_TYPE    = 4'hb; // id page or config register
	localparam int         CFG_SEL_BIT = 2;    // in first address byte
	localparam int         CE_LSB      = 1;    // ce bits sit at [3:1]
	localparam int         IDP_AW      = 7;    // id page address width

	// ****************************************************************
	// reset and delivery values
	// ****************************************************************
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] IDP_RESET = 8'hff;
	localparam int         IDP_BYTES = 64;

	// ****************************************************************
	// bit counting
	// ****************************************************************
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [3:0] CNT_LAST = 4'h7; // eighth data bit
	localparam logic [3:0] CNT_ACK  = 4'h8; // ninth slot

	// select code as sent on the wire, msb first
	typedef struct packed {
		logic [3:0] dev_type;
		logic [2:0] ce;
		logic       rw;
	} sel_code_type;

	// protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_LOCK,
		ST_READ,
		ST_WAIT
	} state_type;

endpackage
`default_nettype wire

// ==== design/scl_bit_capture.sv ====
// link-clock side: samples the data line on each rising serial clock edge
`timescale 1ns/1ns
`default_nettype none
module scl_bit_capture (
	// link clock and reset
	input  wire logic scl_clk,
	input  wire logic rst_n,
	// serial data level
	input  wire logic sda_in,
	// captured bit and toggle event toward the system clock
	output logic      bit_r,
	output logic      tog_r
);

	// ****************************************************************
	// capture
	// ****************************************************************
	// bit stays stable for a whole scl period, so the toggle alone
	// needs synchronising; the bit is read only after it arrives
	always_ff @(posedge scl_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_r <= 1'b0;
			tog_r <= 1'b0;
		end else begin
			bit_r <= sda_in;
			tog_r <= ~tog_r;
		end
	end

endmodule // scl_bit_capture
`default_nettype wire

// ==== design/eeprom_cfg_id_page_read.sv ====
// serial eeprom read logic for the config register and the id page
`timescale 1ns/1ns
`default_nettype none
module eeprom_cfg_id_page_read #(
	parameter int IDP_DEPTH = eeprom_aux_pkg::IDP_BYTES
) (
	// system clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// serial link: scl is both link clock and sampled level
	input  wire logic       scl_clk,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// nonvolatile write engine side (same clock)
	input  wire logic       write_busy,
	input  wire logic       idpage_locked,
	input  wire logic       cfg_load,
	input  wire logic [7:0] cfg_load_data,
	input  wire logic       idp_load,
	input  wire logic [5:0] idp_load_addr,
	input  wire logic [7:0] idp_load_data,
	// status
	output logic            array_sel,
	output logic            read_active,
	output logic [7:0]      chip_enable_config
);

	// ****************************************************************
	// link capture in the scl domain
	// ****************************************************************
	logic link_bit;
	logic link_tog;

	scl_bit_capture u_capture (
		.scl_clk (scl_clk),
		.rst_n   (rst_n),
		.sda_in  (sda_in),
		.bit_r   (link_bit),
		.tog_r   (link_tog)
	);

	// ****************************************************************
	// synchronisers into the system clock
	// ****************************************************************
	logic sda_m_r;
	logic sda_s_r;
	logic sda_d_r;
	logic scl_m_r;
	logic scl_s_r;
	logic scl_d_r;
	logic tog_m_r;
	logic tog_s_r;
	logic tog_d_r;

	// first stages feed only second stages; _d_ is the edge history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
			{scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
			{tog_m_r, tog_s_r, tog_d_r} <= 3'h0;
		end else begin
			{sda_m_r, sda_s_r, sda_d_r} <= {sda_in, sda_m_r, sda_s_r};
			{scl_m_r, scl_s_r, scl_d_r} <= {scl_clk, scl_m_r, scl_s_r};
			{tog_m_r, tog_s_r, tog_d_r} <= {link_tog, tog_m_r, tog_s_r};
		end
	end

	// bus events
	wire bit_ev   = tog_s_r ^ tog_d_r;
	wire scl_fall = scl_d_r & ~scl_s_r;
	wire start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
	wire stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

	// ****************************************************************
	// storage: config register and id page
	// ****************************************************************
	logic [7:0] cfg_r;
	logic [7:0] idp_mem [IDP_DEPTH];

	// write engine loads; reset gives the delivery contents
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= eeprom_aux_pkg::CFG_RESET;
		end else if (cfg_load) begin
			cfg_r <= cfg_load_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < IDP_DEPTH; i++) begin
				idp_mem[i] <= eeprom_aux_pkg::IDP_RESET;
			end
		end else if (idp_load) begin
			idp_mem[idp_load_addr] <= idp_load_data;
		end
	end

	// ****************************************************************
	// protocol registers
	// ****************************************************************
	eeprom_aux_pkg::state_type st_r;
	eeprom_aux_pkg::state_type nxt_r;
	logic [3:0]                cnt_r;
	logic [7:0]                shift_r;
	logic                      ack_r;
	logic                      ackslot_r;
	logic [6:0]                sel7_r;
	logic                      tgt_cfg_r;
	logic [eeprom_aux_pkg::IDP_AW-1:0] addr_r;
	logic                      dummy_done_r;
	logic                      oe_r;
	logic                      array_sel_r;

	// ****************************************************************
	// byte decode
	// ****************************************************************
	wire [7:0] nb = {shift_r[6:0], link_bit};
	wire eeprom_aux_pkg::sel_code_type sel = nb;
	wire ce_match = sel.ce == cfg_r[eeprom_aux_pkg::CE_LSB +: 3];
	wire is_aux   = sel.dev_type == eeprom_aux_pkg::AUX_TYPE;
	wire is_arr   = sel.dev_type == eeprom_aux_pkg::ARRAY_TYPE;
	wire addr_in  = addr_r < IDP_DEPTH;
	wire last_idp = addr_r == 7'(IDP_DEPTH - 1);

	// a read select needs a finished dummy write with the same select
	wire rd_ok = dummy_done_r
		&& (nb[7:1] == sel7_r)
		&& (tgt_cfg_r ? !write_busy : addr_in);
	wire sel_ack = !write_busy && ce_match && is_aux
		&& (!sel.rw || rd_ok);

	// ack decision per byte; busy refuses everything
	wire ack_dec = (st_r == eeprom_aux_pkg::ST_SEL) ? sel_ack :
		(st_r == eeprom_aux_pkg::ST_LOCK) ?
			(!tgt_cfg_r && !idpage_locked && !write_busy) :
		!write_busy;

	// state after the acknowledge slot
	wire eeprom_aux_pkg::state_type nxt_dec =
		!ack_dec ? eeprom_aux_pkg::ST_WAIT :
		(st_r == eeprom_aux_pkg::ST_SEL) ?
			(sel.rw ? eeprom_aux_pkg::ST_READ
			        : eeprom_aux_pkg::ST_ADDR_HI) :
		(st_r == eeprom_aux_pkg::ST_ADDR_HI) ? eeprom_aux_pkg::ST_ADDR_LO :
		(st_r == eeprom_aux_pkg::ST_ADDR_LO) ? eeprom_aux_pkg::ST_LOCK :
		eeprom_aux_pkg::ST_WAIT; // lock query ends; start expected

	// byte presented during reads; config never indexes the page
	wire [7:0] rd_byte = tgt_cfg_r ? cfg_r
		: idp_mem[addr_r[5:0]];
	wire [2:0] rd_idx  = 3'(3'h7 - cnt_r[2:0]);
	wire       rx_state = (st_r == eeprom_aux_pkg::ST_SEL)
		|| (st_r == eeprom_aux_pkg::ST_ADDR_HI)
		|| (st_r == eeprom_aux_pkg::ST_ADDR_LO)
		|| (st_r == eeprom_aux_pkg::ST_LOCK);
	wire byte_end = rx_state && bit_ev && (cnt_r == eeprom_aux_pkg::CNT_LAST);

	// ****************************************************************
	// protocol engine
	// ****************************************************************
	// start always wins: it also cancels the truncated lock query
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r      <= eeprom_aux_pkg::ST_IDLE;
			nxt_r     <= eeprom_aux_pkg::ST_IDLE;
			cnt_r     <= eeprom_aux_pkg::CNT_ZERO;
			shift_r   <= 8'h00;
			ack_r     <= 1'b0;
			ackslot_r <= 1'b0;
			oe_r      <= 1'b0;
		end else if (start_ev) begin
			st_r      <= eeprom_aux_pkg::ST_SEL;
			cnt_r     <= eeprom_aux_pkg::CNT_ZERO;
			ackslot_r <= 1'b0;
			oe_r      <= 1'b0;
		end else if (stop_ev) begin
			st_r      <= eeprom_aux_pkg::ST_IDLE;
			ackslot_r <= 1'b0;
			oe_r      <= 1'b0;
		end else begin
			case (st_r)
				eeprom_aux_pkg::ST_SEL,
				eeprom_aux_pkg::ST_ADDR_HI,
				eeprom_aux_pkg::ST_ADDR_LO,
				eeprom_aux_pkg::ST_LOCK: begin
					if (bit_ev && cnt_r < eeprom_aux_pkg::CNT_ACK) begin
						shift_r <= nb;
						cnt_r   <= cnt_r + 4'h1;
						if (byte_end) begin
							ack_r <= ack_dec;
							nxt_r <= nxt_dec;
						end
					end else if (scl_fall && ackslot_r) begin
						// ack slot over: release, or drive first read bit
						ackslot_r <= 1'b0;
						cnt_r     <= eeprom_aux_pkg::CNT_ZERO;
						st_r      <= nxt_r;
						oe_r      <= (nxt_r == eeprom_aux_pkg::ST_READ)
							&& !rd_byte[7];
					end else if (scl_fall
						&& cnt_r == eeprom_aux_pkg::CNT_ACK) begin
						ackslot_r <= 1'b1;
						oe_r      <= ack_r;
					end
				end
				eeprom_aux_pkg::ST_READ: begin
					if (bit_ev && cnt_r < eeprom_aux_pkg::CNT_ACK) begin
						cnt_r <= cnt_r + 4'h1;
					end else if (bit_ev) begin
						cnt_r <= eeprom_aux_pkg::CNT_ZERO;
						if (link_bit) begin
							st_r <= eeprom_aux_pkg::ST_WAIT;
						end else if (!tgt_cfg_r && last_idp) begin
							st_r <= eeprom_aux_pkg::ST_WAIT;
						end
					end else if (scl_fall) begin
						// master owns the line during its ack slot
						oe_r <= (cnt_r < eeprom_aux_pkg::CNT_ACK)
							&& !rd_byte[rd_idx];
					end
				end
				eeprom_aux_pkg::ST_IDLE,
				eeprom_aux_pkg::ST_WAIT: begin
					oe_r <= 1'b0;
				end
				default: begin
					st_r <= eeprom_aux_pkg::ST_IDLE;
					oe_r <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************************************
	// address counter and transaction memory
	// ****************************************************************
	// only a finished dummy write makes the address meaningful
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel7_r       <= 7'h00;
			tgt_cfg_r    <= 1'b0;
			addr_r       <= '0;
			dummy_done_r <= 1'b0;
		end else if (stop_ev) begin
			dummy_done_r <= 1'b0;
		end else if (byte_end && ack_dec) begin
			case (st_r)
				eeprom_aux_pkg::ST_SEL: begin
					if (!sel.rw) begin
						sel7_r       <= nb[7:1];
						dummy_done_r <= 1'b0;
					end
				end
				eeprom_aux_pkg::ST_ADDR_HI: begin
					tgt_cfg_r <= nb[eeprom_aux_pkg::CFG_SEL_BIT];
				end
				eeprom_aux_pkg::ST_ADDR_LO: begin
					addr_r       <= nb[eeprom_aux_pkg::IDP_AW-1:0];
					dummy_done_r <= 1'b1;
				end
				default: begin
					dummy_done_r <= dummy_done_r;
				end
			endcase
		end else if (st_r == eeprom_aux_pkg::ST_READ && bit_ev
			&& cnt_r == eeprom_aux_pkg::CNT_ACK && !link_bit
			&& !tgt_cfg_r && !last_idp) begin
			addr_r <= addr_r + 7'h01;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// array select is a pulse for the main-array engine elsewhere
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			array_sel_r        <= 1'b0;
			read_active        <= 1'b0;
			chip_enable_config <= eeprom_aux_pkg::CFG_RESET;
			sda_out            <= 1'b0;
		end else begin
			array_sel_r <= byte_end && (st_r == eeprom_aux_pkg::ST_SEL)
				&& is_arr && ce_match && !write_busy;
			read_active        <= st_r == eeprom_aux_pkg::ST_READ;
			chip_enable_config <= cfg_r;
			sda_out            <= 1'b0; // open drain: only pulls low
		end
	end

	assign sda_oe    = oe_r;
	assign array_sel = array_sel_r;

endmodule // eeprom_cfg_id_page_read
`default_nettype wire

// ==== tb/eeprom_cfg_id_page_read_checker.sv ====
// port-level assertions of the aux-space read block
`timescale 1ns/1ns
`default_nettype none
module eeprom_cfg_id_page_read_checker #(
	parameter int IDP_DEPTH = 64
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// watched signals
	input  wire logic       sda_out,
	input  wire logic       sda_oe,
	input  wire logic       write_busy,
	input  wire logic       cfg_load,
	input  wire logic [7:0] cfg_load_data,
	input  wire logic       array_sel,
	input  wire logic [7:0] chip_enable_config
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a driven bit lasts one serial period, about eight clocks
	sequence oe_held;
		sda_oe [*6];
	endsequence
	// whole ack slot left undriven
	sequence quiet_slot;
		!sda_oe [*8];
	endsequence
	chk_drive_low:
		assert property (sda_out == 1'b0) else $error("sda_out high");
	chk_reset_vals:
		assert property ($rose(rst_n) |-> chip_enable_config == 8'h00 && !sda_oe)
		else $error("bad value after reset");
	chk_cfg_load:
		assert property (cfg_load |-> ##2
			chip_enable_config == $past(cfg_load_data, 2))
		else $error("config copy not loaded");
	chk_cfg_hold:
		assert property (!$past(cfg_load, 2) |-> $stable(chip_enable_config))
		else $error("config copy changed");
	chk_array_pulse:
		assert property (array_sel |=> !array_sel) else $error("long array_sel");
	chk_array_quiet:
		assert property (array_sel |-> quiet_slot) else $error("array acked");
	chk_oe_stands:
		assert property ($rose(sda_oe) |-> oe_held) else $error("short drive");
	chk_busy_quiet:
		assert property (write_busy && $past(write_busy, 6) |-> !$rose(sda_oe))
		else $error("acked while busy");
endmodule // eeprom_cfg_id_page_read_checker
`default_nettype wire

// ==== tb/i2c_host.sv ====
// behavioural serial bus controller on the far side of the link
`timescale 1ns/1ns
`default_nettype none
module i2c_host (
	// serial clock, high outside frames
	output logic      scl_clk,
	// resolved data level and our open-drain pull
	input  wire logic sda_in,
	output logic      mst_low
);
	initial begin
		scl_clk = 1'b1;
		mst_low = 1'b0;
	end
	// one slot: data set while low, sampled late in the high phase
	task automatic bit_slot(input logic b, output logic r);
		mst_low = !b;
		#40 scl_clk = 1'b1;
		#70 r = sda_in;
		#10 scl_clk = 1'b0;
		#40;
	endtask
	// extra low time lets the device drop its ack first; the odd 3 ns
	// walks the link phase against the system clock frame by frame
	task automatic start();
		mst_low = 1'b0;
		#83 scl_clk = 1'b1;
		#40 mst_low = 1'b1;
		#40 scl_clk = 1'b0;
		#40;
	endtask
	task automatic stop();
		mst_low = 1'b1;
		#40 scl_clk = 1'b1;
		#40 mst_low = 1'b0;
		#80;
	endtask
	task automatic wr(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(v[i], r);
		bit_slot(1'b1, r);
		ack = !r;
	endtask
	// mack low leaves the byte unacknowledged
	task automatic rd(input logic mack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bit_slot(1'b1, v[i]);
		bit_slot(!mack, r);
	endtask
endmodule // i2c_host
`default_nettype wire

// ==== tb/test_eeprom_cfg_id_page_read.sv ====
// self-checking bench of the aux-space read block
`timescale 1ns/1ns
`default_nettype none
module test_eeprom_cfg_id_page_read;
	logic       clk, rst_n, scl_clk, sda_in, mst_low, sda_out, sda_oe;
	logic       write_busy, idpage_locked, cfg_load, idp_load;
	logic       array_sel, read_active, a;
	logic [7:0] cfg_load_data, idp_load_data, chip_enable_config, d;
	logic [5:0] idp_load_addr;
	int         error_cnt, total_checks;
	// open-drain wire with pull-up
	assign sda_in = !(mst_low || sda_oe);
	eeprom_cfg_id_page_read eeprom_cfg_id_page_read_inst (
		.clk(clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy),
		.idpage_locked(idpage_locked), .cfg_load(cfg_load),
		.cfg_load_data(cfg_load_data), .idp_load(idp_load),
		.idp_load_addr(idp_load_addr), .idp_load_data(idp_load_data),
		.array_sel(array_sel), .read_active(read_active),
		.chip_enable_config(chip_enable_config));
	i2c_host i2c_host_inst (.scl_clk(scl_clk), .sda_in(sda_in),
		.mst_low(mst_low));
	task automatic chk(input string n, input logic [7:0] e, g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// select and two address bytes; a holds the and of the acks
	task automatic setup(input logic [7:0] s, h, l);
		logic x, y;
		i2c_host_inst.start();
		i2c_host_inst.wr(s, a);
		i2c_host_inst.wr(h, x);
		i2c_host_inst.wr(l, y);
		a = a & x & y;
	endtask
	// dummy write then the same select with direction set
	task automatic rrd(input logic [7:0] s, h, l);
		logic x;
		setup(s, h, l);
		x = a;
		i2c_host_inst.start();
		i2c_host_inst.wr(s | 8'h01, a);
		a = a & x;
	endtask
	task automatic load_idp(input logic [5:0] ad, input logic [7:0] v);
		@(negedge clk);
		idp_load = 1'b1;
		idp_load_addr = ad;
		idp_load_data = v;
		@(negedge clk);
		idp_load = 1'b0;
	endtask
	task automatic t_deliv();
		chk("cfg", 8'h00, chip_enable_config);
		rrd(8'hb0, 8'h00, 8'h05);
		i2c_host_inst.rd(1'b0, d);
		i2c_host_inst.stop();
		chk("ack", 8'h01, {7'h0, a});
		chk("idp", 8'hff, d);
		$display("t_deliv done");
	endtask
	task automatic t_cfg();
		@(negedge clk);
		cfg_load = 1'b1;
		cfg_load_data = 8'h0a;
		@(negedge clk);
		cfg_load = 1'b0;
		rrd(8'hba, 8'h04, 8'h00);
		chk("ack", 8'h01, {7'h0, a});
		for (int i = 0; i < 3; i++) begin
			i2c_host_inst.rd(i < 2, d);
			chk("cfg_rd", 8'h0a, d);
			chk("active", {7'h0, i < 2}, {7'h0, read_active});
		end
		i2c_host_inst.stop();
		chk("cfg", 8'h0a, chip_enable_config);
		$display("t_cfg done");
	endtask
	// wrong ce bits, main array type, read select without dummy write
	task automatic t_nak();
		logic [7:0] t [3] = '{8'hb4, 8'haa, 8'hbb};
		for (int i = 0; i < 3; i++) begin
			i2c_host_inst.start();
			i2c_host_inst.wr(t[i], a);
			i2c_host_inst.stop();
			chk("nak", 8'h00, {7'h0, a});
		end
		$display("t_nak done");
	endtask
	// byte 0 differs from ffh so that a wrap would be seen
	task automatic t_idp();
		load_idp(6'h00, 8'h11);
		load_idp(6'h3e, 8'h5c);
		load_idp(6'h3f, 8'h3e);
		load_idp(6'h0a, 8'h77);
		rrd(8'hba, 8'h00, 8'h3e);
		i2c_host_inst.rd(1'b1, d);
		chk("idp62", 8'h5c, d);
		i2c_host_inst.rd(1'b1, d);
		chk("idp63", 8'h3e, d);
		i2c_host_inst.rd(1'b0, d);
		chk("past_end", 8'hff, d);
		i2c_host_inst.stop();
		chk("active", 8'h00, {7'h0, read_active});
		// address beyond the page refuses the read select
		rrd(8'hba, 8'h00, 8'h40);
		i2c_host_inst.stop();
		chk("range", 8'h00, {7'h0, a});
		$display("t_idp done");
	endtask
	task automatic t_busy();
		@(negedge clk);
		write_busy = 1'b1;
		setup(8'hba, 8'h04, 8'h00);
		i2c_host_inst.stop();
		chk("busy", 8'h00, {7'h0, a});
		@(negedge clk);
		write_busy = 1'b0;
		$display("t_busy done");
	endtask
	task automatic t_lock();
		logic x;
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			idpage_locked = k[0];
			setup(8'hba, 8'h00, 8'h00);
			i2c_host_inst.wr(8'h02, x);
			i2c_host_inst.start();
			i2c_host_inst.stop();
			chk("lock", {7'h0, !k[0]}, {7'h0, x});
		end
		rrd(8'hba, 8'h00, 8'h0a);
		i2c_host_inst.rd(1'b0, d);
		i2c_host_inst.stop();
		chk("after", 8'h77, d);
		$display("t_lock done");
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// main sequence
	initial begin
		{rst_n, write_busy, idpage_locked, cfg_load, idp_load} = 5'h00;
		{cfg_load_data, idp_load_data, idp_load_addr} = 22'h0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_deliv();
		t_cfg();
		t_nak();
		t_idp();
		t_busy();
		t_lock();
		wrap_up();
	end
	// watchdog: tests take well under 100 us
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
endmodule // test_eeprom_cfg_id_page_read
bind eeprom_cfg_id_page_read eeprom_cfg_id_page_read_checker #(
	.IDP_DEPTH(IDP_DEPTH)) chk_inst (.clk(clk), .rst_n(rst_n),
	.sda_out(sda_out), .sda_oe(sda_oe), .write_busy(write_busy),
	.cfg_load(cfg_load), .cfg_load_data(cfg_load_data),
	.array_sel(array_sel), .chip_enable_config(chip_enable_config));
`default_nettype wire
